//--- rtl/orx_exec.sv
// execution unit for or, return and rotate instructions
// Function
// [RULE1] immediate or: acc gets acc or imm, only zero flag changes
// [RULE2] memory or: memory byte gets acc or byte, zero flag updated
// [RULE3] subroutine exit pops pc from stack, flags untouched
// [RULE4] exit with immediate pops pc and loads acc with imm, flags untouched
// [RULE5] interrupt exit pops pc and sets global irq enable
// [RULE6] no interrupt serviced while global irq enable is clear; the chained vector at interrupt exit is taken whatever the enable
// [RULE7] pending interrupt at interrupt exit vectors before main program resumes
// [RULE8] rotate left memory byte, old bit 7 into bit 0
// [RULE9] zero flag set when or result is all zeros, else cleared
`default_nettype none
module orx_exec
    import orx_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire orx_instr_t instr,
    input wire logic [7:0] mem_rdata,
    input wire logic [12:0] fetch_pc,
    input wire logic call_push,
    input wire logic irq_pending,
    input wire logic irq_enable_clr,
    output orx_mem_wr_t mem_wr,
    output logic [7:0] acc,
    output logic result_null_flag,
    output logic global_irq_enable,
    output logic [12:0] pc,
    output logic pc_load,
    output logic irq_taken,
    output logic [2:0] stack_depth
);
    typedef struct packed {
        logic [7:0] acc;
        logic zf;
        logic gie;
        logic [12:0] pc;
        logic pc_load;
        logic irq_taken;
        logic [2:0] sp;
        orx_mem_wr_t wr;
    } orx_state_t;

    orx_state_t st;
    orx_state_t next_st;
    logic [12:0] stack_mem [ORX_SDEPTH];
    logic [12:0] pop_pc;
    logic [2:0] pop_sp;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic alu_rot;
    logic [7:0] alu_res;
    logic alu_zero;
    logic push_en;
    logic [12:0] push_val;
    logic [2:0] push_idx;
    // decoded strobes
    logic dec_or_imm;
    logic dec_mem_or;
    logic dec_sub_exit;
    logic dec_exit_imm;
    logic dec_irq_exit;
    logic dec_rot_left;
    logic dec_pop;
    logic dec_flag_upd;
    logic dec_mem_wr;
    logic dec_gie_set;
    logic dec_vector;
    logic irq_chain;
    logic irq_entry;
    logic [2:0] next_sp;

    orx_alu u_alu (
        .a(alu_a),
        .b(alu_b),
        .rotate(alu_rot),
        .result(alu_res),
        .zero(alu_zero)
    );

    assign pop_sp = st.sp - 3'h1;
    assign pop_pc = stack_mem[pop_sp];

    // one-hot decode of the instruction in flight
    always_comb begin
        dec_or_imm = 1'b0;
        dec_mem_or = 1'b0;
        dec_sub_exit = 1'b0;
        dec_exit_imm = 1'b0;
        dec_irq_exit = 1'b0;
        dec_rot_left = 1'b0;
        if (instr.valid) begin
            unique case (instr.op)
                ORX_OP_OR_IMM: begin
                    dec_or_imm = 1'b1;
                end
                ORX_OP_MEM_OR: begin
                    dec_mem_or = 1'b1;
                end
                ORX_OP_SUB_EXIT: begin
                    dec_sub_exit = 1'b1;
                end
                ORX_OP_EXIT_IMM: begin
                    dec_exit_imm = 1'b1;
                end
                ORX_OP_IRQ_EXIT: begin
                    dec_irq_exit = 1'b1;
                end
                ORX_OP_ROT_LEFT: begin
                    dec_rot_left = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // chained interrupt keeps the return address stacked
        irq_chain = dec_irq_exit && irq_pending; // [RULE7]
        dec_pop = dec_sub_exit || dec_exit_imm || (dec_irq_exit && !irq_pending);
        dec_flag_upd = dec_or_imm || dec_mem_or; // [RULE9]
        dec_mem_wr = dec_mem_or || dec_rot_left;
        dec_gie_set = dec_irq_exit && !irq_pending; // [RULE5]
        // service between instructions, only with master enable set
        irq_entry = !instr.valid && st.gie && irq_pending && !call_push; // [RULE6]
        dec_vector = irq_chain || irq_entry;
    end

    // operand select for the shared or/rotate unit
    always_comb begin
        alu_a = st.acc;
        alu_b = instr.imm;
        alu_rot = 1'b0;
        if (dec_mem_or) begin
            alu_b = mem_rdata; // [RULE2]
        end
        if (dec_rot_left) begin
            alu_a = mem_rdata; // [RULE8]
            alu_rot = 1'b1;
        end
    end

    // return stack pointer and push port
    always_comb begin
        push_en = call_push || irq_entry;
        push_val = fetch_pc;
        push_idx = st.sp;
        next_sp = st.sp;
        if (dec_pop) begin
            next_sp = pop_sp; // [RULE3]
        end else if (push_en) begin
            next_sp = st.sp + 3'h1;
        end
    end

    // next state of every field of the state register
    always_comb begin
        next_st = st;
        next_st.pc_load = 1'b0;
        next_st.irq_taken = 1'b0;
        next_st.sp = next_sp;
        next_st.wr.we = dec_mem_wr; // [RULE2]
        if (dec_mem_wr) begin
            next_st.wr.addr = instr.addr;
            next_st.wr.data = alu_res; // [RULE8]
        end
        if (dec_flag_upd) begin
            next_st.zf = alu_zero; // [RULE9]
        end
        if (dec_or_imm) begin
            next_st.acc = alu_res; // [RULE1]
        end
        if (dec_exit_imm) begin
            next_st.acc = instr.imm; // [RULE4]
        end
        if (irq_enable_clr) begin
            next_st.gie = 1'b0;
        end
        if (dec_pop) begin
            next_st.pc = pop_pc; // [RULE3]
            next_st.pc_load = 1'b1;
        end
        if (dec_gie_set) begin
            next_st.gie = 1'b1; // [RULE5]
        end
        if (dec_vector) begin
            next_st.pc = ORX_IRQ_VEC; // [RULE7]
            next_st.pc_load = 1'b1;
            next_st.irq_taken = 1'b1;
            next_st.gie = 1'b0; // [RULE6]
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st.acc <= ORX_ACC_RST;
            st.zf <= 1'b0;
            st.gie <= 1'b0;
            st.pc <= ORX_PC_RST;
            st.pc_load <= 1'b0;
            st.irq_taken <= 1'b0;
            st.sp <= ORX_SP_RST;
            st.wr <= '0;
        end else begin
            st <= next_st;
        end
    end

    // return stack, contents kept through reset
    always_ff @(posedge core_clk) begin
        if (push_en) begin
            stack_mem[push_idx] <= push_val;
        end
    end

    // outputs straight from the state register
    assign mem_wr = st.wr;
    assign acc = st.acc;
    assign result_null_flag = st.zf;
    assign global_irq_enable = st.gie;
    assign pc = st.pc;
    assign pc_load = st.pc_load;
    assign irq_taken = st.irq_taken;
    assign stack_depth = st.sp;
endmodule
`default_nettype wire

//--- rtl/orx_pkg.sv
// package for the or/return/rotate execution block
`default_nettype none
package orx_pkg;
    localparam int ORX_DW = 8;
    localparam int ORX_PCW = 13;
    localparam int ORX_AW = 8;
    localparam int ORX_SDEPTH = 8;
    localparam int ORX_SPW = 3;
    localparam logic [7:0] ORX_ACC_RST = 8'h00;
    localparam logic [12:0] ORX_PC_RST = 13'h0000;
    localparam logic [12:0] ORX_IRQ_VEC = 13'h0004;
    localparam logic [2:0] ORX_SP_RST = 3'h0;

    typedef enum logic [5:0] {
        ORX_OP_OR_IMM = 6'b000001,
        ORX_OP_MEM_OR = 6'b000010,
        ORX_OP_SUB_EXIT = 6'b000100,
        ORX_OP_EXIT_IMM = 6'b001000,
        ORX_OP_IRQ_EXIT = 6'b010000,
        ORX_OP_ROT_LEFT = 6'b100000
    } orx_op_t;

    typedef struct packed {
        logic valid;
        orx_op_t op;
        logic [7:0] imm;
        logic [7:0] addr;
    } orx_instr_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } orx_mem_wr_t;
endpackage
`default_nettype wire

//--- rtl/orx_alu.sv
// combinational or and rotate unit with zero detect
`default_nettype none
module orx_alu
    import orx_pkg::*;
(
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic rotate,
    output logic [7:0] result,
    output logic zero
);
    always_comb begin
        if (rotate) begin
            result = {a[6:0], a[7]}; // [RULE8]
        end else begin
            result = a | b;
        end
        zero = (result == 8'h00); // [RULE9]
    end
endmodule
`default_nettype wire

//--- testbench/orx_exec_monitor.sv
// checker for the or/return/rotate execution block
`default_nettype none
module orx_exec_monitor
    import orx_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire orx_instr_t instr,
    input wire logic [7:0] mem_rdata,
    input wire logic irq_pending,
    input wire orx_mem_wr_t mem_wr,
    input wire logic [7:0] acc,
    input wire logic result_null_flag,
    input wire logic global_irq_enable,
    input wire logic [12:0] pc,
    input wire logic pc_load,
    input wire logic irq_taken,
    input wire logic [2:0] stack_depth
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [5:0] v = instr.valid ? instr.op : 6'h0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_or_acc:
        assert property (v == ORX_OP_OR_IMM |=> acc == ($past(acc) | $past(instr.imm))
            && result_null_flag == (acc == 8'h00)) else $error("bad or");
    a_mem_or:
        assert property (v == ORX_OP_MEM_OR |=> mem_wr.we
            && mem_wr.data == ($past(acc) | $past(mem_rdata))
            && result_null_flag == (mem_wr.data == 8'h00)) else $error("bad mem or");
    a_sub_exit:
        assert property (v == ORX_OP_SUB_EXIT |=> pc_load && $stable(result_null_flag)
            && stack_depth == $past(stack_depth) - 3'h1) else $error("bad exit");
    a_exit_imm:
        assert property (v == ORX_OP_EXIT_IMM |=> pc_load && acc == $past(instr.imm)
            && $stable(result_null_flag)) else $error("bad exit imm");
    a_irq_exit:
        assert property (v == ORX_OP_IRQ_EXIT && !irq_pending |=> global_irq_enable && pc_load)
            else $error("bad irq exit");
    a_irq_gate:
        assert property (!global_irq_enable && v != ORX_OP_IRQ_EXIT |=> !irq_taken)
            else $error("irq while gated");
    a_irq_chain:
        assert property (v == ORX_OP_IRQ_EXIT && irq_pending |=> irq_taken && pc == ORX_IRQ_VEC)
            else $error("no chain");
    a_rot_left:
        assert property (v == ORX_OP_ROT_LEFT |=> mem_wr.we
            && mem_wr.data == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}) else $error("bad rl");
endmodule
bind orx_exec orx_exec_monitor mon(.core_clk, .reset_n, .instr, .mem_rdata, .irq_pending,
    .mem_wr, .acc, .result_null_flag, .global_irq_enable, .pc, .pc_load, .irq_taken,
    .stack_depth);
`default_nettype wire

//--- testbench/or_return_rotate_exec_tb.sv
// testbench for the or/return/rotate execution block
`default_nettype none
module or_return_rotate_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import orx_pkg::*;
    logic core_clk, reset_n, call_push, irq_pending, irq_enable_clr, pc_load, irq_taken;
    orx_instr_t instr;
    orx_mem_wr_t mem_wr;
    logic [7:0] mem_rdata, acc;
    logic result_null_flag, global_irq_enable;
    logic [12:0] fetch_pc, pc;
    logic [2:0] stack_depth;
    int mismatches = 0;
    int n_compared = 0;
    orx_exec dut(.core_clk, .reset_n, .instr, .mem_rdata, .fetch_pc, .call_push, .irq_pending,
        .irq_enable_clr, .mem_wr, .acc, .result_null_flag, .global_irq_enable, .pc, .pc_load,
        .irq_taken, .stack_depth);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input orx_op_t op, input logic [7:0] imm, input logic [7:0] rd);
        @(negedge core_clk);
        instr = '{1'b1, op, imm, 8'h33};
        mem_rdata = rd;
        @(negedge core_clk);
        instr = '0;
    endtask
    task automatic push(input logic [12:0] ret);
        @(negedge core_clk);
        fetch_pc = ret;
        call_push = 1'b1;
        @(negedge core_clk);
        call_push = 1'b0;
    endtask
    task automatic t_or_mem;
        step(ORX_OP_MEM_OR, 8'h00, 8'h00);
        chk({mem_wr, result_null_flag}, 18'h26601);
        step(ORX_OP_OR_IMM, 8'h5a, 8'hff);
        chk({acc, result_null_flag}, 9'h0b4);
        step(ORX_OP_MEM_OR, 8'h00, 8'h81);
        chk(mem_wr, 17'h133db);
        step(ORX_OP_ROT_LEFT, 8'h00, 8'h96);
        chk({mem_wr, result_null_flag}, 18'h2665a);
    endtask
    task automatic t_stack;
        push(13'h1234);
        push(13'h0abc);
        step(ORX_OP_EXIT_IMM, 8'h00, 8'h00);
        chk({pc_load, pc, acc, stack_depth}, 25'h155e001);
        step(ORX_OP_OR_IMM, 8'h00, 8'h00);
        chk({acc, result_null_flag}, 9'h001);
        step(ORX_OP_SUB_EXIT, 8'h00, 8'h00);
        chk({pc_load, pc, stack_depth, result_null_flag}, 18'h32341);
    endtask
    task automatic t_irq;
        logic [2:0] d;
        push(13'h0100);
        step(ORX_OP_IRQ_EXIT, 8'h00, 8'h00);
        chk({global_irq_enable, pc_load, pc, result_null_flag}, 16'hc201);
        irq_pending = 1'b1;
        @(negedge core_clk);
        chk({irq_taken, pc}, 14'h2004);
        irq_enable_clr = 1'b1;
        @(negedge core_clk);
        irq_enable_clr = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({global_irq_enable, irq_taken, stack_depth}, 5'h01);
        push(13'h0200);
        d = stack_depth;
        step(ORX_OP_IRQ_EXIT, 8'h00, 8'h00);
        chk({irq_taken, pc_load, pc, stack_depth}, {15'h6004, d});
        irq_pending = 1'b0;
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        mismatches++;
        end_of_test();
    end
    initial begin
        {reset_n, call_push, irq_pending, irq_enable_clr, instr, mem_rdata, fetch_pc} = '0;
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        t_or_mem();
        t_stack();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
